//--- bench/mls_comparator_properties.sv
// Purpose: Port assertions for the label stack comparator
// Assumes: hready tied to hreadyout, one bus master
// Notes: Bound into every comparator instance
`timescale 1ns/1ns
module mls_checker
    import mls_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic in_ready,
    input wire mls_result_t result
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    sequence s_take;
        hsel && htrans[1] && hready;
    endsequence
    sequence s_wr_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    sequence s_rd_wait;
        !hreadyout [*2] ##1 hreadyout;
    endsequence
    a_write_wait: assert property (s_take ##0 hwrite |=> s_wr_wait)
        else $error("write answer timing wrong");
    a_read_wait: assert property (s_take ##0 !hwrite |=> s_rd_wait)
        else $error("read answer timing wrong");
    a_valid_pulse: assert property (result.valid |=> !result.valid)
        else $error("result valid longer than one cycle");
    a_fields_hold: assert property (!result.valid |-> $stable(result[14:0]))
        else $error("result fields changed without valid");
    a_offset_calc: assert property (result.valid |->
        result.offset == 5'(result.depth * 4) ||
        (result.match && result.offset == 5'(result.depth * 4 + 4)))
        else $error("offset does not follow depth");
    a_depth_bound: assert property (result.valid && result.match |->
        result.depth >= 3'h1 && result.depth <= 3'h4)
        else $error("matched depth out of range");
    a_scan_quiet: assert property ($fell(in_ready) |->
        (!in_ready && !result.valid) [*8])
        else $error("scan ended too early");
    a_scan_bound: assert property ($fell(in_ready) |-> ##[1:40] result.valid)
        else $error("no result after stack");
endmodule

bind mls_comparator mls_checker chk (.core_clk(core_clk), .resetn(resetn), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .in_ready(in_ready), .result(result));

//--- bench/mls_eth_stage.sv
// Purpose: Model of the preceding pipeline stage feeding label words
// Assumes: Called right after a rising clock edge
// Notes: Idle data shows the inverse of the last word
`timescale 1ns/1ns
module mls_eth_stage
    import mls_pkg::*;
(
    input wire logic core_clk,
    input wire logic in_ready,
    output logic in_valid,
    output mls_word_t in_word,
    output logic [CH_W-1:0] in_channel
);
    initial begin
        in_valid = 1'b0;
        in_word = '0;
        in_channel = '0;
    end
    // Gap idle cycles before each later word model a slow stage
    task automatic send(input logic [31:0] w[5], input int n, input logic [CH_W-1:0] ch,
                        input int gap, output bit hung);
        int k;
        hung = 1'b0;
        for (int i = 0; i < n; i++) begin
            if (i > 0 && gap > 0) begin
                in_valid <= 1'b0;
                in_word.data <= ~in_word.data;
                repeat (gap) @(posedge core_clk);
            end
            in_valid <= 1'b1;
            in_word <= '{sof: i == 0, eof: i == n - 1, data: w[i]};
            in_channel <= ch;
            k = 0;
            do begin
                @(posedge core_clk);
                k++;
            end while (in_ready !== 1'b1 && k < 50);
            hung |= k >= 50;
        end
        in_valid <= 1'b0;
        in_word.data <= ~in_word.data;
        in_channel <= ~ch;
    endtask
endmodule

//--- bench/tb.sv
// Purpose: Self-checking bench for the label stack comparator
// Assumes: One bus master, hready looped from hreadyout
// Notes: Each scenario reconfigures the flows it uses
`timescale 1ns/1ns
module tb
    import mls_pkg::*;
;
    logic core_clk, resetn, hsel, hwrite, hreadyout, hresp, in_valid, in_ready;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [CH_W-1:0] in_channel;
    mls_word_t in_word;
    mls_result_t result;
    logic [19:0] lab[4];
    int fails, compares;

    mls_comparator uut (.core_clk(core_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .in_valid(in_valid),
        .in_word(in_word), .in_channel(in_channel), .in_ready(in_ready), .result(result));
    mls_eth_stage src (.core_clk(core_clk), .in_ready(in_ready), .in_valid(in_valid),
        .in_word(in_word), .in_channel(in_channel));

    task automatic end_sim();
        $display("Counts: %0d compares, %0d fails", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        int k;
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do begin
            @(posedge core_clk);
            k++;
        end while (hreadyout !== 1'b1 && k < 100);
        rd = hrdata;
        chk(32'(hresp), 32'(HRESP_OKAY));
        if (k >= 100) begin
            fails++;
            end_sim();
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    function automatic logic [31:0] fa(input int f, input int fld);
        return 32'h200 + 32'(f) * 32'h40 + 32'(fld) * 32'h4;
    endfunction
    task automatic set_flow(input int f, input logic [31:0] cfg, input logic [19:0] lo,
                            input logic [19:0] hi);
        wr(fa(f, 0), cfg);
        for (int i = 0; i < 4; i++) begin
            wr(fa(f, 1 + i), 32'(lo));
            wr(fa(f, 5 + i), 32'(hi));
        end
    endtask
    // Sends n labels plus optional trailer, then checks the verdict
    task automatic run(input int n, input bit te, input logic [31:0] tw, input logic [1:0] ch,
                       input logic m, input logic [2:0] f, input logic [2:0] p, input int tc);
        logic [31:0] w[5];
        logic [14:0] g;
        bit hung;
        int k;
        for (int i = 0; i < 4; i++) begin
            w[i] = {lab[i], 3'h0, i == n - 1, 8'h40};
        end
        w[n] = tw;
        src.send(w, n + te, ch, n % 2, hung);
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (result.valid !== 1'b1 && k < 60);
        if (hung || k >= 60) begin
            fails++;
            end_sim();
        end
        g = result[14:0];
        if (!m) begin
            g[13:11] = f;
        end
        chk(32'(g), 32'({m, f, p, 5'((n + tc) * 4), 3'(n)}));
    endtask

    task automatic t_regs();
        rdc(32'(REG_CTRL), 32'h0);
        rdc(fa(3, 0), 32'h0);
        wr(32'(REG_CTRL), 32'h5);
        wr(32'(REG_PTR_B), 32'h3);
        rdc(32'(REG_CTRL), 32'h5);
        rdc(32'(REG_PTR_B), 32'h3);
        rdc(32'h100, 32'h0);
        wr(fa(0, 9), 32'h1);
        rdc(fa(0, 9), 32'h0);
        wr(fa(0, 1), 32'hFFFF_FFFF);
        rdc(fa(0, 1), 32'h000F_FFFF);
        wr(fa(0, 0), 32'hFFFF_FFFF);
        rdc(fa(0, 0), 32'h0000_0FFF);
        $display("t_regs done");
    endtask
    task automatic t_depth();
        lab = '{20'h00011, 20'h00022, 20'h00033, 20'h00044};
        set_flow(0, 32'hF51, 20'h0, 20'hFFFFF);
        for (int n = 1; n <= 4; n++) begin
            run(n, 1'b0, 32'h0, 2'(n - 1), n % 2, 3'h0, 3'h5, 0);
        end
        $display("t_depth done");
    endtask
    task automatic t_trailer();
        set_flow(0, 32'hF53, 20'h0, 20'hFFFFF);
        run(1, 1'b1, 32'h0ABC_DEF0, 2'h0, 1'b1, 3'h0, 3'h5, 1);
        run(3, 1'b1, 32'h1000_0000, 2'h3, 1'b0, 3'h0, 3'h5, 0);
        run(1, 1'b0, 32'h0, 2'h1, 1'b0, 3'h0, 3'h5, 0);
        $display("t_trailer done");
    endtask
    task automatic t_range();
        lab = '{20'h00100, 20'h00200, 20'h00300, 20'h00400};
        set_flow(0, 32'hF41, 20'h0, 20'hFFFFF);
        wr(fa(0, 2), 32'h200);
        wr(fa(0, 6), 32'h200);
        run(3, 1'b0, 32'h0, 2'h2, 1'b1, 3'h0, 3'h5, 0);
        wr(fa(0, 2), 32'h201);
        run(3, 1'b0, 32'h0, 2'h2, 1'b0, 3'h0, 3'h5, 0);
        wr(fa(0, 0), 32'hF45);
        wr(fa(0, 1), 32'h1);
        wr(fa(0, 5), 32'h0);
        wr(fa(0, 2), 32'h100);
        wr(fa(0, 6), 32'h100);
        wr(fa(0, 4), 32'h300);
        wr(fa(0, 8), 32'h300);
        run(3, 1'b0, 32'h0, 2'h1, 1'b1, 3'h0, 3'h5, 0);
        wr(fa(0, 8), 32'h200);
        run(3, 1'b0, 32'h0, 2'h1, 1'b0, 3'h0, 3'h5, 0);
        $display("t_range done");
    endtask
    task automatic t_chan_set();
        set_flow(0, 32'h419, 20'h0, 20'hFFFFF);
        run(1, 1'b0, 32'h0, 2'h2, 1'b1, 3'h0, 3'h3, 0);
        run(1, 1'b0, 32'h0, 2'h1, 1'b0, 3'h0, 3'h5, 0);
        wr(fa(0, 0), 32'h418);
        run(1, 1'b0, 32'h0, 2'h2, 1'b0, 3'h0, 3'h5, 0);
        $display("t_chan_set done");
    endtask
    task automatic t_mode();
        set_flow(1, 32'hF11, 20'h0, 20'hFFFFF);
        set_flow(2, 32'hF19, 20'h0, 20'hFFFFF);
        run(1, 1'b0, 32'h0, 2'h0, 1'b1, 3'h1, 3'h5, 0);
        wr(32'(REG_CTRL), 32'hD);
        run(1, 1'b0, 32'h0, 2'h3, 1'b1, 3'h2, 3'h3, 0);
        rdc(32'(REG_CTRL), 32'hD);
        rdc(32'(REG_STATUS), 32'h0030_4122);
        $display("t_mode done");
    endtask

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    initial begin
        resetn = 1'b0;
        hsel = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (5) @(posedge core_clk);
        t_regs();
        t_depth();
        t_trailer();
        t_range();
        t_chan_set();
        t_mode();
        end_sim();
    end
endmodule

//--- src/mls_comparator.sv
// Purpose: Label stack comparator stage with AHB-Lite register access
// Assumes: Words arrive from logic on core_clk, one per in_valid/in_ready
// Notes: Flows are scanned one per cycle after the stack is collected
`timescale 1ns/1ns
module mls_comparator
    import mls_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic in_valid,
    input wire mls_word_t in_word,
    input wire logic [CH_W-1:0] in_channel,
    output logic in_ready,
    output mls_result_t result
);
    typedef enum logic [1:0] {BUS_IDLE, BUS_WR, BUS_RD, BUS_RDW} mls_bus_t;
    typedef enum logic [2:0] {E_IDLE, E_LABEL, E_TRAILER, E_EVAL, E_DONE} mls_eng_t;

    typedef struct packed {
        mls_bus_t bus;
        logic [ADDR_W-1:0] addr;
        logic hready;
        logic hresp;
        logic [31:0] hrdata;
        logic [PTR_W-1:0] ptr_a;
        logic [PTR_W-1:0] ptr_b;
        logic mode;
        mls_eng_t eng;
        logic [MAX_LABELS-1:0][LABEL_W-1:0] labels;
        logic [CNT_W-1:0] cnt;
        logic bad;
        logic [CH_W-1:0] chan;
        logic trl_have;
        logic [3:0] trl_nib;
        // One bit wider than a flow index so it can reach FLOWS
        logic [FLOW_W:0] scan;
        logic pend;
        logic [FLOW_W-1:0] pend_flow;
        logic hit;
        logic [FLOW_W-1:0] hit_flow;
        logic hit_set;
        logic hit_trl;
        logic in_ready;
        mls_result_t res;
    } mls_state_t;

    mls_state_t st_q;
    mls_state_t st_d;
    logic rst_n;
    logic mem_wr_en;
    logic [FIELD_W-1:0] mem_wr_field;
    logic mem_rd_en;
    logic [FLOW_W-1:0] mem_rd_flow;
    mls_flow_cfg_t mem_rd_data;
    logic bus_rd_issue;
    logic accept;
    logic sbit;
    logic [LABEL_W-1:0] in_label;

    function automatic logic in_flow_region(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1:FLOW_REGION_LSB] == FLOW_REGION;
    endfunction

    function automatic logic [FIELD_W-1:0] field_of(input logic [ADDR_W-1:0] a);
        return a[FIELD_LSB +: FIELD_W];
    endfunction

    function automatic logic [FLOW_W-1:0] flow_of(input logic [ADDR_W-1:0] a);
        return a[FLOW_IDX_LSB +: FLOW_W];
    endfunction

    // Register view of one stored field
    function automatic logic [31:0] field_read(input mls_flow_cfg_t c,
                                               input logic [FIELD_W-1:0] f);
        logic [31:0] v;
        v = '0;
        if (f == FLD_CFG) begin
            v[CFG_ACT] = c.activation;
            v[CFG_TRL] = c.trailer_word_expected;
            v[CFG_ORG] = c.search_origin_select;
            v[CFG_SET] = c.follow_on_set_select;
            v[CFG_DEPTH_LSB +: MAX_LABELS] = c.allowed_depth_mask;
            v[CFG_CHAN_LSB +: CHANNELS] = c.flow_channel_select;
        end else if (f < FLD_HIGH0) begin
            v[LABEL_W-1:0] = c.label_low_bound[2'(f - FLD_LOW0)];
        end else if (f <= FLD_LAST) begin
            v[LABEL_W-1:0] = c.label_high_bound[2'(f - FLD_HIGH0)];
        end
        return v;
    endfunction

    // Full per-flow verdict on the collected stack
    function automatic logic flow_hits(input mls_flow_cfg_t c,
                                       input logic [MAX_LABELS-1:0][LABEL_W-1:0] lab,
                                       input logic [CNT_W-1:0] cnt,
                                       input logic bad,
                                       input logic [CH_W-1:0] ch,
                                       input logic trl_have,
                                       input logic [3:0] trl_nib);
        logic ok;
        int pos;
        ok = c.activation & c.flow_channel_select[ch] & !bad;
        if (ok) begin
            ok = c.allowed_depth_mask[2'(cnt - 3'h1)];
        end
        // Pairs that fall outside the stack are left unchecked
        for (int i = 0; i < MAX_LABELS; i++) begin
            pos = c.search_origin_select ? int'(cnt) - MAX_LABELS + i : i;
            if (pos >= 0 && pos < int'(cnt)) begin
                if (lab[pos] < c.label_low_bound[i] ||
                    lab[pos] > c.label_high_bound[i]) begin
                    ok = 1'b0;
                end
            end
        end
        if (c.trailer_word_expected && (!trl_have || trl_nib != 4'h0)) begin
            ok = 1'b0;
        end
        return ok;
    endfunction

    mls_rst_sync u_rst_sync (
        .clk(core_clk),
        .rst_n_in(resetn),
        .rst_n_out(rst_n)
    );

    mls_flow_mem u_flow_mem (
        .clk(core_clk),
        .rst_n(rst_n),
        .wr_en(mem_wr_en),
        .wr_flow(flow_of(st_q.addr)),
        .wr_field(mem_wr_field),
        .wr_data(hwdata),
        .rd_en(mem_rd_en),
        .rd_flow(mem_rd_flow),
        .rd_data(mem_rd_data)
    );

    // Word taken only while the registered ready stands
    assign accept = in_valid & st_q.in_ready;
    assign sbit = in_word.data[SBIT_POS];
    assign in_label = in_word.data[LABEL_MSB:LABEL_LSB];

    always_comb begin
        st_d = st_q;
        st_d.res.valid = 1'b0;
        st_d.hresp = HRESP_OKAY;
        mem_wr_en = 1'b0;
        mem_wr_field = field_of(st_q.addr);
        bus_rd_issue = 1'b0;
        mem_rd_en = 1'b0;
        mem_rd_flow = flow_of(st_q.addr);

        // Register bus slave
        // Address phase taken only while ready, so no wait state drops one
        if (hsel && htrans[1] && hready) begin
            st_d.addr = haddr[ADDR_W-1:0];
            st_d.bus = hwrite ? BUS_WR : BUS_RD;
            st_d.hready = 1'b0;
        end else begin
            unique case (st_q.bus)
                BUS_IDLE: begin
                end
                BUS_WR: begin
                    if (st_q.addr == REG_CTRL) begin
                        st_d.ptr_a = hwdata[CTRL_PTR_LSB +: PTR_W];
                        st_d.mode = hwdata[CTRL_MODE];
                    end else if (st_q.addr == REG_PTR_B) begin
                        st_d.ptr_b = hwdata[CTRL_PTR_LSB +: PTR_W];
                    end else if (in_flow_region(st_q.addr)) begin
                        mem_wr_en = 1'b1;
                    end
                    st_d.hready = 1'b1;
                    st_d.bus = BUS_IDLE;
                end
                BUS_RD: begin
                    // Memory read one cycle ahead of the read data
                    bus_rd_issue = in_flow_region(st_q.addr);
                    st_d.bus = BUS_RDW;
                end
                BUS_RDW: begin
                    st_d.hrdata = '0;
                    if (st_q.addr == REG_CTRL) begin
                        st_d.hrdata[CTRL_PTR_LSB +: PTR_W] = st_q.ptr_a;
                        st_d.hrdata[CTRL_MODE] = st_q.mode;
                    end else if (st_q.addr == REG_PTR_B) begin
                        st_d.hrdata[CTRL_PTR_LSB +: PTR_W] = st_q.ptr_b;
                    end else if (st_q.addr == REG_STATUS) begin
                        st_d.hrdata[ST_BUSY] = st_q.eng != E_IDLE;
                        st_d.hrdata[ST_MATCH] = st_q.res.match;
                        st_d.hrdata[ST_FLOW_LSB +: FLOW_W] = st_q.res.flow;
                        st_d.hrdata[ST_DEPTH_LSB +: CNT_W] = st_q.res.depth;
                        st_d.hrdata[ST_OFFSET_LSB +: OFFSET_W] = st_q.res.offset;
                        st_d.hrdata[ST_PTR_LSB +: PTR_W] = st_q.res.next_ptr;
                    end else if (in_flow_region(st_q.addr)) begin
                        st_d.hrdata = field_read(mem_rd_data, field_of(st_q.addr));
                    end
                    st_d.hready = 1'b1;
                    st_d.bus = BUS_IDLE;
                end
            endcase
        end

        // Stack collection and flow scan
        unique case (st_q.eng)
            E_IDLE: begin
                if (accept && in_word.sof) begin
                    st_d.labels = '0;
                    st_d.labels[0] = in_label;
                    st_d.cnt = CNT_W'(1);
                    st_d.chan = in_channel;
                    st_d.bad = 1'b0;
                    st_d.trl_have = 1'b0;
                    st_d.trl_nib = 4'h0;
                    st_d.scan = '0;
                    st_d.pend = 1'b0;
                    st_d.hit = 1'b0;
                    if (sbit) begin
                        st_d.eng = in_word.eof ? E_EVAL : E_TRAILER;
                    end else if (in_word.eof) begin
                        st_d.bad = 1'b1;
                        st_d.eng = E_EVAL;
                    end else begin
                        st_d.eng = E_LABEL;
                    end
                end
            end
            E_LABEL: begin
                if (accept) begin
                    st_d.labels[st_q.cnt[1:0]] = in_label;
                    st_d.cnt = st_q.cnt + CNT_W'(1);
                    if (sbit) begin
                        st_d.eng = in_word.eof ? E_EVAL : E_TRAILER;
                    // Fourth label without bottom bit, or early frame end
                    end else if (st_q.cnt == CNT_W'(MAX_LABELS - 1) || in_word.eof) begin
                        st_d.bad = 1'b1;
                        st_d.eng = E_EVAL;
                    end
                end
            end
            E_TRAILER: begin
                // Word after the bottom label is the trailer candidate
                if (accept) begin
                    st_d.trl_have = 1'b1;
                    st_d.trl_nib = in_word.data[TRL_NIB_MSB:TRL_NIB_LSB];
                    st_d.eng = E_EVAL;
                end
            end
            E_EVAL: begin
                if (st_q.pend && flow_hits(mem_rd_data, st_q.labels, st_q.cnt, st_q.bad,
                                           st_q.chan, st_q.trl_have, st_q.trl_nib)) begin
                    if (!st_q.hit || st_q.mode) begin
                        st_d.hit = 1'b1;
                        st_d.hit_flow = st_q.pend_flow;
                        st_d.hit_set = mem_rd_data.follow_on_set_select;
                        st_d.hit_trl = mem_rd_data.trailer_word_expected;
                    end
                end
                st_d.pend = 1'b0;
                // One record read per cycle; scan stalls while the bus reads
                if (!bus_rd_issue && st_q.scan != (FLOW_W + 1)'(FLOWS)) begin
                    mem_rd_en = 1'b1;
                    mem_rd_flow = st_q.scan[FLOW_W-1:0];
                    st_d.pend = 1'b1;
                    st_d.pend_flow = st_q.scan[FLOW_W-1:0];
                    st_d.scan = st_q.scan + (FLOW_W + 1)'(1);
                end else if (st_q.scan == (FLOW_W + 1)'(FLOWS) && !st_q.pend) begin
                    st_d.eng = E_DONE;
                end
            end
            E_DONE: begin
                st_d.res.valid = 1'b1;
                st_d.res.match = st_q.hit;
                st_d.res.flow = st_q.hit_flow;
                st_d.res.depth = st_q.cnt;
                // No match reports set A and no trailer octets
                st_d.res.next_ptr = (st_q.hit && st_q.hit_set) ?
                    st_q.ptr_b : st_q.ptr_a;
                st_d.res.offset = OFFSET_W'((int'(st_q.cnt) + int'(st_q.hit && st_q.hit_trl))
                                            * WORD_OCTETS);
                st_d.eng = E_IDLE;
            end
            default: begin
                st_d.eng = E_IDLE;
            end
        endcase
        // Bus read owns the memory port over the scan
        if (bus_rd_issue) begin
            mem_rd_en = 1'b1;
            mem_rd_flow = flow_of(st_q.addr);
        end
        // Ready from the next state, so it stays registered
        st_d.in_ready = st_d.eng == E_IDLE || st_d.eng == E_LABEL || st_d.eng == E_TRAILER;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
            // Bus ready idles high so the first address phase is taken
            st_q.hready <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign hreadyout = st_q.hready;
    assign hresp = st_q.hresp;
    assign hrdata = st_q.hrdata;
    assign in_ready = st_q.in_ready;
    assign result = st_q.res;
endmodule

//--- src/mls_flow_mem.sv
// Purpose: Per-flow match settings, field-wise write, whole-record read
// Assumes: One write and one read per cycle
// Notes: Read data is registered, valid the cycle after rd_en
`timescale 1ns/1ns
module mls_flow_mem
    import mls_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [FLOW_W-1:0] wr_flow,
    input wire logic [FIELD_W-1:0] wr_field,
    input wire logic [31:0] wr_data,
    input wire logic rd_en,
    input wire logic [FLOW_W-1:0] rd_flow,
    output mls_flow_cfg_t rd_data
);
    typedef struct packed {
        mls_flow_cfg_t [FLOWS-1:0] rec;
        mls_flow_cfg_t rd;
    } mls_mem_state_t;

    mls_mem_state_t st_q;
    mls_mem_state_t st_d;

    always_comb begin
        st_d = st_q;
        if (wr_en) begin
            if (wr_field == FLD_CFG) begin
                st_d.rec[wr_flow].activation = wr_data[CFG_ACT];
                st_d.rec[wr_flow].trailer_word_expected = wr_data[CFG_TRL];
                st_d.rec[wr_flow].search_origin_select = wr_data[CFG_ORG];
                st_d.rec[wr_flow].follow_on_set_select = wr_data[CFG_SET];
                st_d.rec[wr_flow].allowed_depth_mask = wr_data[CFG_DEPTH_LSB +: MAX_LABELS];
                st_d.rec[wr_flow].flow_channel_select = wr_data[CFG_CHAN_LSB +: CHANNELS];
            end else if (wr_field < FLD_HIGH0) begin
                st_d.rec[wr_flow].label_low_bound[2'(wr_field - FLD_LOW0)] =
                    wr_data[LABEL_W-1:0];
            end else if (wr_field <= FLD_LAST) begin
                st_d.rec[wr_flow].label_high_bound[2'(wr_field - FLD_HIGH0)] =
                    wr_data[LABEL_W-1:0];
            end
        end
        if (rd_en) begin
            st_d.rd = st_q.rec[rd_flow];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign rd_data = st_q.rd;
endmodule

//--- src/mls_pkg.sv
// Purpose: Shared constants and carrier types for the label stack comparator
// Assumes: 32-bit AHB-Lite register bus, word access only
// Notes: Flow records live in mls_flow_mem; shared settings in the top
package mls_pkg;

    localparam int FLOWS = 8;
    localparam int FLOW_W = 3;
    localparam int CHANNELS = 4;
    localparam int CH_W = 2;
    localparam int MAX_LABELS = 4;
    localparam int CNT_W = 3;
    localparam int LABEL_W = 20;
    localparam int WORD_OCTETS = 4;
    localparam int OFFSET_W = 5;
    localparam int PTR_W = 3;
    localparam int ADDR_W = 12;
    localparam int FIELD_W = 4;

    // Label word layout
    localparam int LABEL_MSB = 31;
    localparam int LABEL_LSB = 12;
    localparam int SBIT_POS = 8;
    localparam int TRL_NIB_MSB = 31;
    localparam int TRL_NIB_LSB = 28;

    // Register map, byte addresses
    localparam logic [ADDR_W-1:0] REG_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] REG_PTR_B = 12'h004;
    localparam logic [ADDR_W-1:0] REG_STATUS = 12'h008;
    localparam logic [2:0] FLOW_REGION = 3'h1;
    localparam int FLOW_REGION_LSB = 9;
    localparam int FLOW_IDX_LSB = 6;
    localparam int FIELD_LSB = 2;

    // Fields of one flow record
    localparam logic [FIELD_W-1:0] FLD_CFG = 4'h0;
    localparam logic [FIELD_W-1:0] FLD_LOW0 = 4'h1;
    localparam logic [FIELD_W-1:0] FLD_HIGH0 = 4'h5;
    localparam logic [FIELD_W-1:0] FLD_LAST = 4'h8;

    // Flow config word bits
    localparam int CFG_ACT = 0;
    localparam int CFG_TRL = 1;
    localparam int CFG_ORG = 2;
    localparam int CFG_SET = 3;
    localparam int CFG_DEPTH_LSB = 4;
    localparam int CFG_CHAN_LSB = 8;

    // Control and status bits
    localparam int CTRL_PTR_LSB = 0;
    localparam int CTRL_MODE = 3;
    localparam int ST_BUSY = 0;
    localparam int ST_MATCH = 1;
    localparam int ST_FLOW_LSB = 4;
    localparam int ST_DEPTH_LSB = 8;
    localparam int ST_OFFSET_LSB = 12;
    localparam int ST_PTR_LSB = 20;

    localparam logic HRESP_OKAY = 1'b0;

    typedef struct packed {
        logic activation;
        logic trailer_word_expected;
        logic search_origin_select;
        logic follow_on_set_select;
        logic [MAX_LABELS-1:0] allowed_depth_mask;
        logic [CHANNELS-1:0] flow_channel_select;
        logic [MAX_LABELS-1:0][LABEL_W-1:0] label_low_bound;
        logic [MAX_LABELS-1:0][LABEL_W-1:0] label_high_bound;
    } mls_flow_cfg_t;

    typedef struct packed {
        logic sof;
        logic eof;
        logic [31:0] data;
    } mls_word_t;

    typedef struct packed {
        logic valid;
        logic match;
        logic [FLOW_W-1:0] flow;
        logic [PTR_W-1:0] next_ptr;
        logic [OFFSET_W-1:0] offset;
        logic [CNT_W-1:0] depth;
    } mls_result_t;

endpackage

//--- src/mls_rst_sync.sv
// Purpose: Releases the asynchronous reset through two flip-flops
// Assumes: Reset input active low
// Notes: Assertion is immediate, release follows two clock edges
`timescale 1ns/1ns
module mls_rst_sync (
    input wire logic clk,
    input wire logic rst_n_in,
    output logic rst_n_out
);
    logic [1:0] sync_q;
    logic [1:0] sync_d;

    always_comb begin
        sync_d = {sync_q[0], 1'b1};
    end

    always_ff @(posedge clk or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync_q <= 2'h0;
        end else begin
            sync_q <= sync_d;
        end
    end

    assign rst_n_out = sync_q[1];
endmodule
